// ### core/vid_regbank_pkg.sv
// Constants, register layout and state encoding for the serial VID register bank.
// Assumes a single system clock of CLK_PERIOD_NS; all timing is counted on it.
package vid_regbank_pkg;

  // Register indices carried in the index byte
  localparam logic [7:0] IDX_VID  = 8'h00;
  localparam logic [7:0] IDX_CTRL = 8'h01;

  // Voltage register: code in the low bits, check bit on top
  localparam int         VID_CODE_W   = 7;
  localparam int         VID_PAR_BIT  = 7;
  localparam logic [7:0] VID_RESET    = 8'h32;

  // Control register fields
  localparam int         CTRL_INT_MODE_BIT   = 7;
  localparam int         CTRL_PROT_CHG_BIT   = 4;
  localparam int         CTRL_LIGHT_LOAD_BIT = 3;
  localparam int         CTRL_LATCH_OFF_BIT  = 0;
  localparam logic [7:0] CTRL_RESET          = 8'h09;
  localparam logic [7:0] CTRL_WR_MASK        = 8'h99;

  // Serial framing
  localparam logic [2:0] BIT_LAST  = 3'h7;
  localparam logic [6:0] ADDR_DEFAULT = 7'h2a;

  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int SPIKE_NS      = 32;
  localparam int SPIKE_CYCLES  = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROT_HOLD_DEFAULT = 255;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_ADDR      = 4'h1,
    ST_ADDR_ACK  = 4'h3,
    ST_INDEX     = 4'h2,
    ST_INDEX_ACK = 4'h6,
    ST_WDATA     = 4'h7,
    ST_WDATA_ACK = 4'h5,
    ST_RDATA     = 4'h4,
    ST_SKIP      = 4'hc
  } link_state_t;

endpackage

// ### core/line_if.sv
// Filtered level and edge strobes of one serial bus line.
// Assumes the filter side drives all three signals on clk_i.
`timescale 1ns/10ps
`default_nettype none

interface line_if;
  logic level;
  logic rise;
  logic fall;

  modport filt (output level, output rise, output fall);
  modport user (input level, input rise, input fall);
endinterface

`default_nettype wire

// ### core/glitch_filter.sv
// Synchroniser and spike filter for one serial bus pin.
// Assumes the pin is asynchronous to clk_i; edges are one-cycle strobes.
`timescale 1ns/10ps
`default_nettype none

module glitch_filter
  import vid_regbank_pkg::*;
#(
  parameter int STABLE_CYCLES = SPIKE_CYCLES + 1
) (
  input  wire logic  clk_i,
  input  wire logic  nrst_i,
  input  wire logic  pin_i,
  line_if.filt       line
);
  localparam int CW = $clog2(STABLE_CYCLES + 1);
  localparam logic [CW-1:0] CNT_DONE = CW'(STABLE_CYCLES - 1);

  logic          meta_q;
  logic          sync_q;
  logic          level_q;
  logic          rise_q;
  logic          fall_q;
  logic [CW-1:0] cnt_q;

  // Bus idles high, so the chain resets high
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end
    else
    begin
      meta_q <= pin_i;
      sync_q <= meta_q;
    end
  end

  // A change must persist longer than the spike width before it is believed
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      level_q <= 1'b1;
      rise_q  <= 1'b0;
      fall_q  <= 1'b0;
      cnt_q   <= '0;
    end
    else
    begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      if (sync_q == level_q)
        cnt_q <= '0;
      else if (cnt_q == CNT_DONE)
      begin
        cnt_q   <= '0;
        level_q <= sync_q; // see [RULE_12]
        rise_q  <= sync_q;
        fall_q  <= ~sync_q;
      end
      else
        cnt_q <= cnt_q + 1'b1;
    end
  end

  assign line.level = level_q;
  assign line.rise  = rise_q;
  assign line.fall  = fall_q;
endmodule

`default_nettype wire

// ### core/vid_serial_register_bank.sv
// Serial-bus slave holding the output voltage code and the regulator control byte.
// Assumes SCL and SDA arrive as raw pins; SDA is open drain, resolved outside.
// What this block does
// [RULE_01] Voltage register holds a 7-bit code low, odd check bit on top.
// [RULE_02] Voltage code resets to 0110010, the 1.068750V target.
// [RULE_03] Control bit 7 picks register control when 1, external when 0 (reset).
// [RULE_04] Control bit 4 set suppresses protection while the code changes; resets 0.
// [RULE_05] Control bit 3 picks fixed-width (1, reset) or pulse-skip (0) light load.
// [RULE_06] Control bit 0 picks latch-off (1, reset) or auto-recovery (0).
// [RULE_07] Master sets voltage bit 7 to the XNOR of the seven code bits.
// [RULE_08] Bad check bit: no data acknowledge, stored code unchanged.
// [RULE_09] A refused control write leaves the control register unchanged.
// [RULE_10] Master repeats a write whose data byte was not acknowledged.
// [RULE_11] Voltage register reads return the stored check bit with the code.
// [RULE_12] SCL and SDA spikes up to 32 ns are never taken as edges.
// [RULE_13] After START compare the 7-bit address; acknowledge on the ninth clock.
// [RULE_14] No address match: no acknowledge, ignore data, wait for next START.
// [RULE_15] Bit after the address: 0 is write, 1 is read.
// [RULE_16] Reads shift out eight bits, then idle until STOP regardless of acknowledge.
// [RULE_17] Writes carry an index byte: 0 voltage register, 1 control register.
// [RULE_18] Control bits 6, 5, 2, 1 read as zero and ignore writes.
`timescale 1ns/10ps
`default_nettype none

module vid_serial_register_bank
  import vid_regbank_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = ADDR_DEFAULT, // Arbitrary value, set per board
  parameter int         PROT_HOLD  = PROT_HOLD_DEFAULT
) (
  input  wire logic                                   clk_i,
  input  wire logic                                   nrst_i,
  input  wire logic                                   scl_i,
  input  wire logic                                   sda_i,
  output var  logic                                   sda_o,
  output var  logic                                   sda_oe_o,
  output var  logic [vid_regbank_pkg::VID_CODE_W-1:0] vid_code_o,
  output var  logic                                   internal_mode_o,
  output var  logic                                   prot_suppress_o,
  output var  logic                                   light_load_skip_n_o,
  output var  logic                                   latch_off_o
);
  import vid_regbank_pkg::*;

  localparam int PW = $clog2(PROT_HOLD + 1);
  localparam logic [PW-1:0] PROT_LOAD = PW'(PROT_HOLD);
  localparam logic [PW-1:0] PROT_ONE  = PW'(1);

  // Odd check: bit 7 must equal the XNOR of the code bits
  function automatic logic parity_ok(input logic [7:0] b);
    parity_ok = (b[VID_PAR_BIT] == ~(^b[VID_CODE_W-1:0]));
  endfunction

  line_if scl_line ();
  line_if sda_line ();

  glitch_filter u_scl_filt (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .pin_i  (scl_i),
    .line   (scl_line)
  );

  glitch_filter u_sda_filt (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .pin_i  (sda_i),
    .line   (sda_line)
  );

  link_state_t state_q;
  logic [2:0]  cnt_q;
  logic [7:0]  sh_q;
  logic        ack_q;
  logic        ack_seen_q;
  logic        rw_q;
  logic        idx_q;
  logic [7:0]  vid_q;
  logic [7:0]  ctrl_q;
  logic [PW-1:0] prot_cnt_q;
  logic        prot_q;
  logic        oe_q;
  logic        sda_out_q;

  logic        start_det;
  logic        stop_det;
  logic [7:0]  rx_byte;
  logic        byte_done;
  logic        addr_match;
  logic        idx_valid;
  logic        data_ok;
  logic [7:0]  rd_byte;
  logic        wr_vid;
  logic        wr_ctrl;
  logic        code_change;

  // Both lines pass through identical filters, so their ordering survives
  assign start_det = sda_line.fall & scl_line.level;
  assign stop_det  = sda_line.rise & scl_line.level;
  assign rx_byte   = {sh_q[6:0], sda_line.level};
  assign byte_done = scl_line.rise & (cnt_q == BIT_LAST);

  assign addr_match = (rx_byte[7:1] == SLAVE_ADDR); // see [RULE_13]
  assign idx_valid  = (rx_byte == IDX_VID) | (rx_byte == IDX_CTRL); // see [RULE_17]
  assign data_ok    = idx_q ? 1'b1 : parity_ok(rx_byte); // see [RULE_08]
  assign rd_byte    = idx_q ? ctrl_q : vid_q; // see [RULE_11]

  always_comb
  begin
    wr_vid      = 1'b0;
    wr_ctrl     = 1'b0;
    code_change = 1'b0;
    if ((state_q == ST_WDATA) && byte_done && !start_det && !stop_det)
    begin
      wr_vid  = ~idx_q & parity_ok(rx_byte); // see [RULE_08]
      wr_ctrl = idx_q & data_ok; // see [RULE_09]
    end
    code_change = wr_vid & (rx_byte[VID_CODE_W-1:0] != vid_q[VID_CODE_W-1:0]);
  end

  // Frame sequencing; a START anywhere restarts address reception
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_q    <= ST_IDLE;
      cnt_q      <= '0;
      sh_q       <= '0;
      ack_q      <= 1'b0;
      ack_seen_q <= 1'b0;
      rw_q       <= 1'b0;
    end
    else if (start_det)
    begin
      state_q    <= ST_ADDR; // see [RULE_13]
      cnt_q      <= '0;
      ack_seen_q <= 1'b0;
    end
    else if (stop_det)
    begin
      state_q    <= ST_IDLE; // see [RULE_16]
      ack_seen_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_ADDR, ST_INDEX, ST_WDATA:
        begin
          if (scl_line.rise)
          begin
            sh_q  <= rx_byte;
            cnt_q <= cnt_q + 1'b1;
          end
          if (byte_done)
          begin
            cnt_q <= '0;
            case (state_q)
              ST_ADDR:
              begin
                ack_q   <= addr_match;
                rw_q    <= rx_byte[0]; // see [RULE_15]
                state_q <= addr_match ? ST_ADDR_ACK : ST_SKIP; // see [RULE_14]
              end
              ST_INDEX:
              begin
                ack_q   <= idx_valid;
                state_q <= ST_INDEX_ACK;
              end
              default:
              begin
                ack_q   <= data_ok; // see [RULE_08]
                state_q <= ST_WDATA_ACK;
              end
            endcase
          end
        end
        ST_ADDR_ACK, ST_INDEX_ACK, ST_WDATA_ACK:
        begin
          if (scl_line.rise)
            ack_seen_q <= 1'b1;
          if (scl_line.fall && ack_seen_q)
          begin
            ack_seen_q <= 1'b0;
            cnt_q      <= '0;
            case (state_q)
              ST_ADDR_ACK:
              begin
                if (rw_q)
                begin
                  state_q <= ST_RDATA;
                  sh_q    <= rd_byte;
                end
                else
                  state_q <= ST_INDEX;
              end
              ST_INDEX_ACK:
                state_q <= ack_q ? ST_WDATA : ST_SKIP;
              default:
                state_q <= ST_SKIP; // Single data byte per write
            endcase
          end
        end
        ST_RDATA:
        begin
          if (scl_line.fall)
          begin
            if (cnt_q == BIT_LAST)
              state_q <= ST_SKIP; // see [RULE_16]
            else
            begin
              cnt_q <= cnt_q + 1'b1;
              sh_q  <= {sh_q[6:0], 1'b0};
            end
          end
        end
        ST_IDLE, ST_SKIP:
          state_q <= state_q;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // SDA is changed on SCL falling edges; a START or STOP, seen while SCL is high, only releases it
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      oe_q <= 1'b0;
    else if (start_det || stop_det)
      oe_q <= 1'b0;
    else if (scl_line.fall)
    begin
      case (state_q)
        ST_ADDR_ACK, ST_INDEX_ACK, ST_WDATA_ACK:
        begin
          if (!ack_seen_q)
            oe_q <= ack_q; // see [RULE_13]
          else if ((state_q == ST_ADDR_ACK) && rw_q)
            oe_q <= ~rd_byte[7];
          else
            oe_q <= 1'b0;
        end
        ST_RDATA:
          oe_q <= (cnt_q == BIT_LAST) ? 1'b0 : ~sh_q[6]; // see [RULE_16]
        default:
          oe_q <= 1'b0;
      endcase
    end
  end

  // Open drain: the data level is always low, only the enable moves
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      sda_out_q <= 1'b0;
    else
      sda_out_q <= 1'b0;
  end

  // Index persists so a later read returns the register last addressed
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      idx_q <= 1'b0;
    else if ((state_q == ST_INDEX) && byte_done && idx_valid && !start_det && !stop_det)
      idx_q <= rx_byte[0]; // see [RULE_17]
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      vid_q <= VID_RESET; // see [RULE_02]
    else if (wr_vid)
      vid_q <= rx_byte; // see [RULE_01]
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      ctrl_q <= CTRL_RESET; // see [RULE_05]
    else if (wr_ctrl)
      ctrl_q <= rx_byte & CTRL_WR_MASK; // see [RULE_18]
  end

  // Suppression window after a code change; the ramp length is fixed by PROT_HOLD
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      prot_cnt_q <= '0;
      prot_q     <= 1'b0;
    end
    else if (code_change && ctrl_q[CTRL_PROT_CHG_BIT])
    begin
      prot_cnt_q <= PROT_LOAD; // see [RULE_04]
      prot_q     <= 1'b1;
    end
    else if (prot_cnt_q != '0)
    begin
      prot_cnt_q <= prot_cnt_q - PROT_ONE;
      prot_q     <= (prot_cnt_q > PROT_ONE);
    end
    else
      prot_q <= 1'b0;
  end

  assign sda_o               = sda_out_q;
  assign sda_oe_o            = oe_q;
  assign vid_code_o          = vid_q[VID_CODE_W-1:0];
  assign internal_mode_o     = ctrl_q[CTRL_INT_MODE_BIT]; // see [RULE_03]
  assign prot_suppress_o     = prot_q;
  assign light_load_skip_n_o = ctrl_q[CTRL_LIGHT_LOAD_BIT]; // see [RULE_05]
  assign latch_off_o         = ctrl_q[CTRL_LATCH_OFF_BIT]; // see [RULE_06]
endmodule

`default_nettype wire

// ### bench/vid_regbank_assertions.sv
// Concurrent checks on the pins of the serial VID register bank.
// Assumes a bench SCL of many clk cycles per half period and no clock stretching.
`timescale 1ns/10ps
`default_nettype none

module vid_regbank_assertions
  import vid_regbank_pkg::*;
#(
  parameter int PROT_HOLD = 4
) (
  input wire logic                                   clk_i,
  input wire logic                                   nrst_i,
  input wire logic                                   scl_i,
  input wire logic                                   sda_o,
  input wire logic                                   sda_oe_o,
  input wire logic [vid_regbank_pkg::VID_CODE_W-1:0] vid_code_o,
  input wire logic                                   internal_mode_o,
  input wire logic                                   prot_suppress_o,
  input wire logic                                   light_load_skip_n_o,
  input wire logic                                   latch_off_o
);
  logic [15:0] hold_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // Length of the current suppression window, read back when it ends
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      hold_q <= '0;
    else if (prot_suppress_o)
      hold_q <= hold_q + 16'h1;
    else
      hold_q <= '0;
  end

  AST_RESET_VALUES:
  assert property ($rose(nrst_i) |-> vid_code_o == 7'h32 && !internal_mode_o && !prot_suppress_o
    && light_load_skip_n_o && latch_off_o && !sda_oe_o) else $error("reset values wrong");
  AST_OPEN_DRAIN:
  assert property (sda_o == 1'b0) else $error("sda driven high");
  AST_VID_THEN_ACK:
  assert property ($changed(vid_code_o) |-> ##[1:20] sda_oe_o) else $error("vid change unacked");
  AST_CTRL_THEN_ACK:
  assert property ($changed({internal_mode_o, light_load_skip_n_o, latch_off_o})
    |-> ##[1:20] sda_oe_o) else $error("ctrl change unacked");
  // Raw SCL may carry a rejected spike when the filtered rise lands, so look at it earlier
  AST_VID_UPDATE_TIME:
  assert property ($changed(vid_code_o) |-> $past(scl_i, 5) && !sda_oe_o)
    else $error("vid update misplaced");
  AST_PROT_CAUSE:
  assert property ($rose(prot_suppress_o) |-> vid_code_o != $past(vid_code_o, 2))
    else $error("suppress without code change");
  AST_PROT_LENGTH:
  assert property ($fell(prot_suppress_o) |-> hold_q == 16'(PROT_HOLD))
    else $error("suppress length wrong");
  AST_ACK_IN_LOW:
  assert property ($rose(sda_oe_o) |-> !scl_i ##1 !scl_i) else $error("sda pulled while scl high");
endmodule

bind vid_serial_register_bank vid_regbank_assertions #(.PROT_HOLD(PROT_HOLD)) u_chk (
  .clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .vid_code_o(vid_code_o), .internal_mode_o(internal_mode_o),
  .prot_suppress_o(prot_suppress_o), .light_load_skip_n_o(light_load_skip_n_o),
  .latch_off_o(latch_off_o));

`default_nettype wire

// ### bench/i2c_master_model.sv
// Behavioural serial-bus master, 160 ns bit clock made from clk_i.
// Assumes a pulled-up SDA wire resolved by the bench; SCL stands high between frames.
`timescale 1ns/10ps
`default_nettype none

module i2c_master_model (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output var  logic scl_o,
  output var  logic sda_low_o
);
  logic spike_en;

  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    spike_en = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Data changes mid-low and is sampled mid-high; a spike pulls SCL low for 4 cycles after the sample
  task automatic bit_cycle(input logic b, output logic s);
    sda_low_o <= !b;
    tick(5);
    scl_o <= 1'b1;
    tick(5);
    s = sda_i;
    if (spike_en)
    begin
      scl_o <= 1'b0;
      tick(4);
      scl_o <= 1'b1;
      tick(1);
    end
    else
      tick(5);
    scl_o <= 1'b0;
    tick(5);
  endtask

  task automatic start_cond();
    sda_low_o <= 1'b0;
    tick(5);
    scl_o <= 1'b1;
    tick(5);
    sda_low_o <= 1'b1;
    tick(5);
    scl_o <= 1'b0;
    tick(5);
  endtask

  task automatic stop_cond();
    sda_low_o <= 1'b1;
    tick(5);
    scl_o <= 1'b1;
    tick(5);
    sda_low_o <= 1'b0;
    tick(10);
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cycle(d[i], s);
    bit_cycle(1'b1, s);
    ack = !s;
  endtask

  // One byte only, answered with a NACK
  task automatic recv_byte(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_cycle(1'b1, s);
      d[i] = s;
    end
    bit_cycle(1'b1, s);
  endtask

  // Caller repeats the whole write when a bad check bit leaves the data byte unacknowledged
  task automatic wr(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d,
                    output logic [2:0] acks);
    start_cond();
    send_byte({a, 1'b0}, acks[2]);
    send_byte(idx, acks[1]);
    send_byte(d, acks[0]);
    stop_cond();
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] idx, output logic [7:0] d);
    logic x;
    start_cond();
    send_byte({a, 1'b0}, x);
    send_byte(idx, x);
    start_cond();
    send_byte({a, 1'b1}, x);
    recv_byte(d);
    stop_cond();
  endtask
endmodule

`default_nettype wire

// ### bench/vid_serial_register_bank_tb.sv
// Self-checking bench for the serial VID register bank.
// Assumes the master model drives the bus; SDA is the wired AND of both drivers.
`timescale 1ns/10ps
`default_nettype none

module vid_serial_register_bank_tb;
  import vid_regbank_pkg::*;
  localparam logic [6:0] A = ADDR_DEFAULT;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic scl, sda_low, sda_o, sda_oe, imode, prot, lload, latch;
  logic [6:0] vid;
  logic [7:0] rdat;
  logic [2:0] acks;
  int fails = 0;
  int checks_done = 0;
  int prot_cycles = 0;
  wire sda = !(sda_low || sda_oe);

  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) if (prot === 1'b1) prot_cycles++;

  vid_serial_register_bank #(.PROT_HOLD(4)) u_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .vid_code_o(vid), .internal_mode_o(imode), .prot_suppress_o(prot),
    .light_load_skip_n_o(lload), .latch_off_o(latch));
  i2c_master_model u_mst (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));

  task automatic finish_test();
    if (fails == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [7:0] par(input logic [6:0] c);
    return {~^c, c};
  endfunction

  task automatic t_reset();
    chk("pins", 8'h32, {1'b0, vid});
    chk("ctrl_pins", 8'h03, {5'h0, imode, lload, latch});
    u_mst.rd(A, IDX_VID, rdat);
    chk("vid_read", 8'h32, rdat);
    u_mst.rd(A, IDX_CTRL, rdat);
    chk("ctrl_read", 8'h09, rdat);
  endtask

  task automatic t_vid(input logic [6:0] c);
    u_mst.wr(A, IDX_VID, par(c), acks);
    chk("vid_acks", 8'h07, {5'h0, acks});
    chk("vid_pin", {1'b0, c}, {1'b0, vid});
    u_mst.rd(A, IDX_VID, rdat);
    chk("vid_read", par(c), rdat);
  endtask

  task automatic t_bad_parity();
    u_mst.wr(A, IDX_VID, par(7'h11) ^ 8'h80, acks);
    chk("bad_acks", 8'h06, {5'h0, acks});
    chk("bad_keep", 8'h55, {1'b0, vid});
    t_vid(7'h11);
  endtask

  task automatic t_ctrl(input logic [7:0] d);
    u_mst.wr(A, IDX_CTRL, d, acks);
    chk("ctrl_acks", 8'h07, {5'h0, acks});
    chk("ctrl_pins", {5'h0, d[7], d[3], d[0]}, {5'h0, imode, lload, latch});
    u_mst.rd(A, IDX_CTRL, rdat);
    chk("ctrl_read", d & 8'h99, rdat);
  endtask

  // The refused data byte differs from the control value, so a wrong write shows up
  task automatic t_refused();
    u_mst.wr(A ^ 7'h01, IDX_VID, par(7'h40), acks);
    chk("addr_acks", 8'h00, {5'h0, acks});
    chk("addr_keep", 8'h11, {1'b0, vid});
    u_mst.wr(A, 8'h02, 8'h99, acks);
    chk("idx_acks", 8'h04, {5'h0, acks});
    chk("idx_pins", 8'h00, {5'h0, imode, lload, latch});
    u_mst.rd(A, IDX_CTRL, rdat);
    chk("idx_keep", 8'h00, rdat);
  endtask

  task automatic t_prot();
    t_ctrl(8'h10);
    prot_cycles = 0;
    u_mst.wr(A, IDX_VID, par(7'h2c), acks);
    chk("prot_len", 8'h04, 8'(prot_cycles));
    prot_cycles = 0;
    u_mst.wr(A, IDX_VID, par(7'h2c), acks);
    chk("prot_same", 8'h00, 8'(prot_cycles));
  endtask

  task automatic t_spike();
    u_mst.spike_en = 1'b1;
    t_vid(7'h6a);
    u_mst.spike_en = 1'b0;
  endtask

  initial
  begin
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    t_reset();
    t_vid(7'h00);
    t_vid(7'h7f);
    t_vid(7'h55);
    chk("no_prot", 8'h00, 8'(prot_cycles));
    t_bad_parity();
    t_ctrl(8'hff);
    t_ctrl(8'h00);
    t_refused();
    t_prot();
    t_spike();
    finish_test();
  end

  // About 24 transfers of 580 to 780 cycles each, with ample margin
  initial
  begin
    repeat (60000) @(posedge clk_i);
    fails++;
    finish_test();
  end
endmodule

`default_nettype wire
